// [hdl/twdbg_pkg.sv]
// Constants, types and decode helpers for the two-wire debug port.
// Assumes a 125 MHz core clock and a host-driven debug clock.
package twdbg_pkg;

  // ********************************************
  // Instruction codes, command byte bits 7..3
  // ********************************************
  localparam logic [4:0] OP_ERASE = 5'h02;
  localparam logic [4:0] OP_WR_CFG = 5'h03;
  localparam logic [4:0] OP_RD_CFG = 5'h04;
  localparam logic [4:0] OP_PC_RD = 5'h05;
  localparam logic [4:0] OP_STATUS = 5'h06;
  localparam logic [4:0] OP_BRK_SET = 5'h07;
  localparam logic [4:0] OP_HALT = 5'h08;
  localparam logic [4:0] OP_RESUME = 5'h09;
  localparam logic [4:0] OP_INJECT = 5'h0a;
  localparam logic [4:0] OP_STEP = 5'h0b;
  localparam logic [4:0] OP_REPLACE = 5'h0c;
  localparam logic [4:0] OP_IDENT = 5'h0d;

  // ********************************************
  // Command byte fields
  // ********************************************
  localparam int CMD_CODE_LSB = 3;
  localparam int CMD_RESP_BIT = 2;
  localparam int BITS_PER_BYTE = 8;

  // ********************************************
  // Configuration and status byte fields
  // ********************************************
  localparam int CFG_TIMERS_OFF = 3;
  localparam int CFG_DMA_PAUSE = 2;
  localparam int CFG_TIMER_SUSP = 1;
  localparam int CFG_INFO_PAGE = 0;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam int ST_ERASE_DONE = 7;
  localparam int ST_CPU_IDLE = 6;
  localparam int ST_CPU_HALTED = 5;
  localparam int ST_PM0 = 4;
  localparam int ST_HALT_CAUSE = 3;
  localparam int ST_LOCKED = 2;
  localparam int ST_OSC_STABLE = 1;
  localparam int ST_STACK_OVF = 0;

  // ********************************************
  // Entry and timing
  // ********************************************
  localparam logic [1:0] ENTRY_EDGES = 2'h2;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RESP_GAP_NS = 200;
  localparam int RESP_GAP_CYCLES = (RESP_GAP_NS * 1000) / CLK_PERIOD_PS;

  // ********************************************
  // Carriers
  // ********************************************
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] arg3;
  } twdbg_cmd_type;

  typedef struct packed {
    logic eraseDone;
    logic cpuIdle;
    logic cpuHalted;
    logic powerMode0;
    logic haltByBreak;
    logic oscStable;
    logic stackOverflow;
  } twdbg_cpu_stat_type;

  typedef enum logic [1:0] {
    INSTR_INJECT = 2'b00,
    INSTR_STEP = 2'b01,
    INSTR_REPLACE = 2'b10
  } twdbg_instr_kind_type;

  // Response bytes a command clocks back to the host
  function automatic logic [1:0] respBytes(input logic [7:0] cmd);
    logic [4:0] code;
    code = cmd[7:CMD_CODE_LSB];
    if (code == OP_PC_RD || code == OP_IDENT) begin
      respBytes = 2'h2;
    end else begin
      respBytes = {1'b0, cmd[CMD_RESP_BIT]};
    end
  endfunction

endpackage

// [hdl/twdbg_link.sv]
// Link side of the debug port, clocked by the host debug clock.
// Assumes linkRstN is released before the first command edge.
`timescale 1ns/1ps
module twdbg_link (
  input wire logic dbgClk,
  input wire logic linkRstN,
  input wire logic dataIn,
  input wire logic [15:0] respWord,
  output logic dataOut,
  output logic dataOe,
  output twdbg_pkg::twdbg_cmd_type cmdWord,
  output logic reqToggle
);

  logic txPhase_reg;
  logic [2:0] bitCnt_reg;
  logic [1:0] byteIdx_reg;
  logic [3:0] txCnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] respLeft_reg;
  twdbg_pkg::twdbg_cmd_type cmd_reg;
  logic req_reg;

  // ********************************************
  // Byte assembly, MSB first
  // ********************************************
  wire [7:0] rxByte = {shift_reg[6:0], dataIn};
  wire byteDone = (bitCnt_reg == 3'h7);
  wire [1:0] extraBytes = (byteIdx_reg == 2'h0) ? rxByte[1:0] : cmd_reg.cmd[1:0];
  wire lastByte = (byteIdx_reg == extraBytes);
  wire [1:0] respCnt = twdbg_pkg::respBytes((byteIdx_reg == 2'h0) ? rxByte : cmd_reg.cmd);
  wire [3:0] txLast = (respLeft_reg == 2'h2) ? 4'hf : 4'h7;
  wire [3:0] txIndex = 4'hf - txCnt_reg;

  // Host bits sampled on the falling edge
  always_ff @(negedge dbgClk or negedge linkRstN) begin
    if (!linkRstN) begin
      txPhase_reg <= 1'b0;
      bitCnt_reg <= 3'h0;
      byteIdx_reg <= 2'h0;
      txCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      respLeft_reg <= 2'h0;
      cmd_reg <= '0;
      req_reg <= 1'b0;
    end else if (txPhase_reg) begin
      txCnt_reg <= txCnt_reg + 4'h1;
      if (txCnt_reg == txLast) begin
        txPhase_reg <= 1'b0;
        txCnt_reg <= 4'h0;
      end
    end else begin
      shift_reg <= rxByte;
      bitCnt_reg <= bitCnt_reg + 3'h1;
      if (byteDone) begin
        unique case (byteIdx_reg)
          2'h0: cmd_reg.cmd <= rxByte;
          2'h1: cmd_reg.arg1 <= rxByte;
          2'h2: cmd_reg.arg2 <= rxByte;
          2'h3: cmd_reg.arg3 <= rxByte;
        endcase
        byteIdx_reg <= byteIdx_reg + 2'h1;
        if (lastByte) begin
          byteIdx_reg <= 2'h0;
          req_reg <= ~req_reg;
          respLeft_reg <= respCnt;
          txPhase_reg <= (respCnt != 2'h0);
        end
      end
    end
  end

  // Response driven on the rising edge
  always_ff @(posedge dbgClk or negedge linkRstN) begin
    if (!linkRstN) begin
      dataOut <= 1'b0;
      dataOe <= 1'b0;
    end else begin
      dataOut <= txPhase_reg ? respWord[txIndex] : 1'b0;
      dataOe <= txPhase_reg;
    end
  end

  assign cmdWord = cmd_reg;
  assign reqToggle = req_reg;

endmodule // twdbg_link

// [hdl/twdbg_port.sv]
// Two-wire debug port: entry, command execution and lock handling.
// Assumes CPU, flash and status inputs are on clk.
`timescale 1ns/1ps
module twdbg_port #(
  parameter logic [15:0] CHIP_ID = 16'h1234, // Arbitrary identifier
  parameter logic [15:0] VERSION = 16'h0001 // Arbitrary version
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dbgClk,
  input wire logic chipResetPinN,
  input wire logic dataIn,
  input wire logic lockStrap,
  input wire logic [15:0] progCounter,
  input wire twdbg_pkg::twdbg_cpu_stat_type cpuStat,
  output logic dataOut,
  output logic dataOe,
  output logic debugPinsOwned,
  output logic [3:0] debugConfig,
  output logic debugLock,
  output logic eraseStart,
  output logic haltReq,
  output logic resumeReq,
  output logic breakSet,
  output logic [23:0] breakData,
  output logic instrValid,
  output twdbg_pkg::twdbg_instr_kind_type instrKind,
  output logic [1:0] instrLen,
  output logic [23:0] instrBytes
);

  // ********************************************
  // Pin synchronisers for entry detection
  // ********************************************
  logic clkMeta_reg;
  logic clkSync_reg;
  logic clkPrev_reg;
  logic rstMeta_reg;
  logic rstSync_reg;
  logic [1:0] entryCnt_reg;
  logic debugMode_reg;
  logic linkRun_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clkMeta_reg <= 1'b0;
      clkSync_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      clkMeta_reg <= dbgClk;
      clkSync_reg <= clkMeta_reg;
      clkPrev_reg <= clkSync_reg;
      rstMeta_reg <= chipResetPinN;
      rstSync_reg <= rstMeta_reg;
    end
  end

  wire dbgClkRise = clkSync_reg & ~clkPrev_reg;
  wire entryEdge = dbgClkRise & ~rstSync_reg & ~debugMode_reg;
  wire [1:0] entryCnt_next = entryEdge ? entryCnt_reg + 2'h1 : entryCnt_reg;

  // Entry: two rising edges while chip reset held low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      entryCnt_reg <= 2'h0;
      debugMode_reg <= 1'b0;
      linkRun_reg <= 1'b0;
    end else begin
      entryCnt_reg <= entryCnt_next;
      // Link waits for chip reset release, skipping the entry clock's falling edges
      linkRun_reg <= debugMode_reg & rstSync_reg;
      if (entryCnt_next == twdbg_pkg::ENTRY_EDGES) begin
        debugMode_reg <= 1'b1;
      end
    end
  end

  // Pins released to general purpose use outside debug mode
  assign debugPinsOwned = debugMode_reg;

  // ********************************************
  // Link domain
  // ********************************************
  twdbg_pkg::twdbg_cmd_type linkCmd;
  logic linkReq;
  logic [15:0] resp_reg;

  // Link held in reset until debug mode is entered and chip reset is released
  twdbg_link uLink (
    .dbgClk(dbgClk),
    .linkRstN(linkRun_reg),
    .dataIn(dataIn),
    .respWord(resp_reg),
    .dataOut(dataOut),
    .dataOe(dataOe),
    .cmdWord(linkCmd),
    .reqToggle(linkReq)
  );

  // ********************************************
  // Request toggle crossing
  // ********************************************
  logic reqMeta_reg;
  logic reqSync_reg;
  logic reqPrev_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reqMeta_reg <= 1'b0;
      reqSync_reg <= 1'b0;
      reqPrev_reg <= 1'b0;
    end else begin
      reqMeta_reg <= linkReq;
      reqSync_reg <= reqMeta_reg;
      reqPrev_reg <= reqSync_reg;
    end
  end

  wire cmdArrive = reqSync_reg ^ reqPrev_reg;

  // ********************************************
  // Command decode
  // ********************************************
  wire [4:0] opCode = linkCmd.cmd[7:twdbg_pkg::CMD_CODE_LSB];
  wire isErase = (opCode == twdbg_pkg::OP_ERASE);
  wire isStatus = (opCode == twdbg_pkg::OP_STATUS);
  wire isIdent = (opCode == twdbg_pkg::OP_IDENT);
  wire isHaltOnly = (opCode == twdbg_pkg::OP_RESUME) || (opCode == twdbg_pkg::OP_INJECT) ||
    (opCode == twdbg_pkg::OP_STEP) || (opCode == twdbg_pkg::OP_REPLACE);
  logic lock_reg;
  logic eraseOk_reg;
  wire lockPass = ~lock_reg | isErase | isStatus | isIdent;
  wire haltPass = ~isHaltOnly | cpuStat.cpuHalted;
  wire doCmd = cmdArrive & lockPass & haltPass;

  // ********************************************
  // Status byte
  // ********************************************
  logic [7:0] statusByte;
  always_comb begin
    statusByte = 8'h00;
    statusByte[twdbg_pkg::ST_ERASE_DONE] = cpuStat.eraseDone;
    statusByte[twdbg_pkg::ST_CPU_IDLE] = cpuStat.cpuIdle;
    statusByte[twdbg_pkg::ST_CPU_HALTED] = cpuStat.cpuHalted;
    statusByte[twdbg_pkg::ST_PM0] = cpuStat.powerMode0;
    statusByte[twdbg_pkg::ST_HALT_CAUSE] = cpuStat.haltByBreak;
    statusByte[twdbg_pkg::ST_LOCKED] = lock_reg;
    statusByte[twdbg_pkg::ST_OSC_STABLE] = cpuStat.oscStable;
    statusByte[twdbg_pkg::ST_STACK_OVF] = cpuStat.stackOverflow;
  end

  // ********************************************
  // Response selection
  // ********************************************
  logic [3:0] cfg_reg;
  logic [15:0] resp_next;
  always_comb begin
    resp_next = 16'h0000;
    if (doCmd) begin
      unique case (opCode)
        twdbg_pkg::OP_RD_CFG: resp_next = {4'h0, cfg_reg, 8'h00};
        twdbg_pkg::OP_STATUS: resp_next = {statusByte, 8'h00};
        twdbg_pkg::OP_PC_RD: resp_next = progCounter;
        twdbg_pkg::OP_IDENT: resp_next = {CHIP_ID[7:0], VERSION[7:0]};
        default: resp_next = {statusByte, 8'h00};
      endcase
    end
  end

  // ********************************************
  // Lock, erase gate and configuration
  // ********************************************
  logic strapDone_reg;

  // Lock strap caught after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strapDone_reg <= 1'b0;
      lock_reg <= 1'b0;
      eraseOk_reg <= 1'b1;
      cfg_reg <= twdbg_pkg::CFG_RESET;
      resp_reg <= 16'h0000;
    end else begin
      strapDone_reg <= 1'b1;
      if (!strapDone_reg) begin
        lock_reg <= lockStrap;
      end else if (doCmd && isErase && eraseOk_reg) begin
        lock_reg <= 1'b0;
      end
      if (cmdArrive && !isStatus) begin
        eraseOk_reg <= 1'b0;
      end
      if (doCmd && opCode == twdbg_pkg::OP_WR_CFG) begin
        cfg_reg <= linkCmd.arg1[3:0];
      end
      if (cmdArrive) begin
        resp_reg <= resp_next;
      end
    end
  end

  assign debugConfig = cfg_reg;
  assign debugLock = lock_reg;

  // ********************************************
  // CPU and flash requests
  // ********************************************
  twdbg_pkg::twdbg_instr_kind_type kind_next;
  always_comb begin
    unique case (opCode)
      twdbg_pkg::OP_STEP: kind_next = twdbg_pkg::INSTR_STEP;
      twdbg_pkg::OP_REPLACE: kind_next = twdbg_pkg::INSTR_REPLACE;
      default: kind_next = twdbg_pkg::INSTR_INJECT;
    endcase
  end

  wire isInstr = (opCode == twdbg_pkg::OP_INJECT) || (opCode == twdbg_pkg::OP_STEP) ||
    (opCode == twdbg_pkg::OP_REPLACE);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eraseStart <= 1'b0;
      haltReq <= 1'b0;
      resumeReq <= 1'b0;
      breakSet <= 1'b0;
      breakData <= 24'h000000;
      instrValid <= 1'b0;
      instrKind <= twdbg_pkg::INSTR_INJECT;
      instrLen <= 2'h0;
      instrBytes <= 24'h000000;
    end else begin
      eraseStart <= doCmd & isErase & eraseOk_reg;
      haltReq <= doCmd & (opCode == twdbg_pkg::OP_HALT);
      resumeReq <= doCmd & (opCode == twdbg_pkg::OP_RESUME);
      breakSet <= doCmd & (opCode == twdbg_pkg::OP_BRK_SET);
      instrValid <= doCmd & isInstr;
      if (doCmd) begin
        breakData <= {linkCmd.arg1, linkCmd.arg2, linkCmd.arg3};
        instrKind <= kind_next;
        instrLen <= linkCmd.cmd[1:0];
        instrBytes <= {linkCmd.arg1, linkCmd.arg2, linkCmd.arg3};
      end
    end
  end

endmodule // twdbg_port

// [testbench/twdbg_port_assertions.sv]
// Concurrent checks on the debug port top-level ports.
// Assumes binding to twdbg_port; all checks on the core clock.
`timescale 1ns/1ps
module twdbg_port_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic dbgClk,
  input wire logic chipResetPinN,
  input wire twdbg_pkg::twdbg_cpu_stat_type cpuStat,
  input wire logic dataOut,
  input wire logic dataOe,
  input wire logic debugPinsOwned,
  input wire logic [3:0] debugConfig,
  input wire logic debugLock,
  input wire logic eraseStart,
  input wire logic haltReq,
  input wire logic resumeReq,
  input wire logic breakSet,
  input wire logic instrValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_gone(s);
    ##1 !s;
  endsequence

  sequence s_unlocked;
    ##[0:1] !debugLock;
  endsequence

  chk_erase_pulse: assert property (eraseStart |-> s_gone(eraseStart))
    else $error("erase start held past one cycle");
  chk_halt_pulse: assert property (haltReq |-> s_gone(haltReq))
    else $error("halt request held past one cycle");
  chk_erase_unlocks: assert property (eraseStart |-> s_unlocked)
    else $error("lock not cleared by erase");
  chk_cmd_unlocked: assert property ((haltReq || resumeReq || breakSet || instrValid)
    |-> !debugLock)
    else $error("command acted while locked");
  chk_cfg_locked: assert property ($changed(debugConfig) |-> !$past(debugLock))
    else $error("config changed while locked");
  chk_entry_reset: assert property ($rose(debugPinsOwned) |-> !$past(chipResetPinN, 2))
    else $error("debug mode entered without chip reset");
  chk_oe_owned: assert property (dataOe |-> debugPinsOwned)
    else $error("data driven outside debug mode");
  chk_data_edge: assert property (($changed(dataOut) || $changed(dataOe)) |-> dbgClk)
    else $error("data changed away from rising debug clock");
  chk_resume_halted: assert property (resumeReq |-> $past(cpuStat.cpuHalted))
    else $error("resume while running");
  chk_instr_halted: assert property (instrValid |-> $past(cpuStat.cpuHalted))
    else $error("instruction issued while running");
endmodule // twdbg_port_assertions

bind twdbg_port twdbg_port_assertions chk_u (.clk(clk), .nrst(nrst), .dbgClk(dbgClk),
  .chipResetPinN(chipResetPinN), .cpuStat(cpuStat), .dataOut(dataOut), .dataOe(dataOe),
  .debugPinsOwned(debugPinsOwned), .debugConfig(debugConfig), .debugLock(debugLock),
  .eraseStart(eraseStart), .haltReq(haltReq), .resumeReq(resumeReq), .breakSet(breakSet),
  .instrValid(instrValid));

// [testbench/twdbg_host.sv]
// Debug host model: makes debug clock, sends commands, reads answers.
// Assumes the device drives the data line only while dataOe is high.
`timescale 1ns/1ps
module twdbg_host (
  output logic dbgClk,
  output logic chipResetPinN,
  output logic dataIn,
  input wire logic dataOut,
  input wire logic dataOe
);
  logic hostBit;

  assign dataIn = dataOe ? dataOut : hostBit;

  initial begin
    dbgClk = 1'b0;
    chipResetPinN = 1'b1;
    hostBit = 1'b0;
  end

  task automatic enter();
    chipResetPinN = 1'b0;
    repeat (2) begin
      #43 dbgClk = 1'b1;
      #40 dbgClk = 1'b0;
    end
    #40 chipResetPinN = 1'b1;
    #100;
  endtask

  // Clock stands still between frames
  task automatic xfer(input logic [31:0] b, input int nb, input int nr,
    output logic [15:0] r);
    int i;
    r = 16'h0000;
    #3;
    for (i = 0; i < nb * 8; i++) begin
      dbgClk = 1'b1;
      hostBit = b[31 - i];
      #16 dbgClk = 1'b0;
      #16;
    end
    #200;
    for (i = 0; i < nr * 8; i++) begin
      dbgClk = 1'b1;
      hostBit = ~hostBit;
      #16 r = {r[14:0], dataIn};
      dbgClk = 1'b0;
      #16;
    end
    if (nr == 1) r = {r[7:0], 8'h00};
    #200;
  endtask
endmodule // twdbg_host

// [testbench/tb.sv]
// Self-checking bench for the two-wire debug port.
// Assumes twdbg_host drives the debug pins; CPU side modelled here.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [31:0] bytes;
    logic halted;
    logic [15:0] resp;
    logic [4:0] mask;
  } twdbg_row_type;
  logic clk, nrst, lockStrap, dbgClk, chipResetPinN, dataIn, dataOut, dataOe;
  logic debugPinsOwned, debugLock, eraseStart, haltReq, resumeReq, breakSet, instrValid;
  logic [15:0] progCounter;
  logic [3:0] debugConfig;
  logic [23:0] breakData, instrBytes;
  logic [1:0] instrLen;
  logic [4:0] seen;
  twdbg_pkg::twdbg_cpu_stat_type cpuStat;
  twdbg_pkg::twdbg_instr_kind_type instrKind;
  int miscompares = 0;
  int samplesChecked = 0;
  // Mask order: erase, halt, resume, break, instruction
  twdbg_row_type rows [16] = '{
    '{32'h10000000, 1'b0, 16'h0000, 5'h10}, '{32'h190a0000, 1'b0, 16'h0000, 5'h00},
    '{32'h24000000, 1'b0, 16'h0a00, 5'h00}, '{32'h28000000, 1'b0, 16'hbeef, 5'h00},
    '{32'h68000000, 1'b0, 16'h3401, 5'h00}, '{32'h34000000, 1'b0, 16'h8200, 5'h00},
    '{32'h10000000, 1'b0, 16'h0000, 5'h00}, '{32'h4c000000, 1'b0, 16'h0000, 5'h00},
    '{32'h51a50000, 1'b0, 16'h0000, 5'h00}, '{32'h44000000, 1'b0, 16'h8200, 5'h08},
    '{32'h3b112233, 1'b0, 16'h0000, 5'h02}, '{32'h4c000000, 1'b1, 16'ha200, 5'h04},
    '{32'h34000000, 1'b1, 16'ha200, 5'h00}, '{32'h51a50000, 1'b1, 16'h0000, 5'h01},
    '{32'h5c000000, 1'b1, 16'ha200, 5'h01}, '{32'h62c33c00, 1'b1, 16'h0000, 5'h01}};

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) seen <= seen | {eraseStart, haltReq, resumeReq, breakSet, instrValid};

  twdbg_port dut_u (.clk(clk), .nrst(nrst), .dbgClk(dbgClk), .chipResetPinN(chipResetPinN),
    .dataIn(dataIn), .lockStrap(lockStrap), .progCounter(progCounter), .cpuStat(cpuStat),
    .dataOut(dataOut), .dataOe(dataOe), .debugPinsOwned(debugPinsOwned),
    .debugConfig(debugConfig), .debugLock(debugLock), .eraseStart(eraseStart),
    .haltReq(haltReq), .resumeReq(resumeReq), .breakSet(breakSet), .breakData(breakData),
    .instrValid(instrValid), .instrKind(instrKind), .instrLen(instrLen),
    .instrBytes(instrBytes));
  twdbg_host host_u (.dbgClk(dbgClk), .chipResetPinN(chipResetPinN), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe(dataOe));

  // ********************************************
  // Compare, command and reset tasks
  // ********************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bits(input logic [4:0] got, input logic [4:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t bits %b expected %b", $time, got, exp);
    end
  endtask

  task automatic run(input twdbg_row_type w);
    logic [15:0] r;
    int nr;
    @(negedge clk);
    cpuStat.cpuHalted = w.halted;
    seen = 5'h00;
    nr = (w.bytes[31:27] == 5'h05 || w.bytes[31:27] == 5'h0d) ? 2 : int'(w.bytes[26]);
    host_u.xfer(w.bytes, int'(w.bytes[25:24]) + 1, nr, r);
    cmp_word(r, w.resp);
    cmp_bits(seen, w.mask);
  endtask

  task automatic do_reset(input logic lock);
    @(negedge clk);
    nrst = 1'b0;
    lockStrap = lock;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    cmp_word({10'h0, debugPinsOwned, debugLock, debugConfig}, {11'h0, lock, 4'h0});
    host_u.enter();
    @(negedge clk);
    cmp_bits({4'h0, debugPinsOwned}, 5'h01);
  endtask

  // ********************************************
  // Main sequence and watchdog
  // ********************************************
  initial begin
    nrst = 1'b0;
    lockStrap = 1'b0;
    progCounter = 16'hbeef;
    cpuStat = 7'b1000010;
    seen = 5'h00;
    do_reset(1'b0);
    for (int i = 0; i < 16; i++) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    cmp_word({debugConfig, instrKind, instrLen, instrBytes[23:16]}, 16'haac3);
    cmp_word(breakData[15:0], 16'h3c33);
    do_reset(1'b1);
    run('{32'h34000000, 1'b0, 16'h8600, 5'h00});
    run('{32'h10000000, 1'b0, 16'h0000, 5'h10});
    cmp_bits({4'h0, debugLock}, 5'h00);
    $display("erase unlock test done");
    do_reset(1'b1);
    run('{32'h19050000, 1'b0, 16'h0000, 5'h00});
    run('{32'h24000000, 1'b0, 16'h0000, 5'h00});
    run('{32'h68000000, 1'b0, 16'h3401, 5'h00});
    run('{32'h10000000, 1'b0, 16'h0000, 5'h00});
    run('{32'h44000000, 1'b0, 16'h0000, 5'h00});
    cmp_bits({1'b0, debugLock, debugConfig[2:0]}, 5'h08);
    $display("locked test done");
    close_out();
  end

  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule // tb
